// file: rtl/buck_regs_pkg.sv
// Purpose: Constants and types for the buck voltage setting register bank
// Assumes: Byte-wide register port with 9-bit address, one clock
// Notes: Voltage code maps 0.30 V + code * 10 mV
// Operation
// R1 - Buck A ceiling code held, 7 bits; applied code never exceeds it; a_code_o can exceed it one cycle after a load or write lowers it
// R2 - Buck B ceiling code held, 7 bits; applied code never exceeds it; b_code_o can exceed it one cycle after a load or write lowers it
// R3 - Ceilings loaded from OTP; writable only in test mode
// R4 - Voltage code linear, 10 mV steps, zero is 0.30 V, ones 1.57 V
// R5 - Buck A first setting: bit 7 low forced PWM, high automatic
// R6 - Buck A second setting: bit 7 low forced PWM, high automatic
// R7 - Buck B first setting: bit 7 low forced PWM, high automatic
// R8 - Buck B second setting: bit 7 low forced PWM, high automatic
// R9 - Target codes sit in bits 6 to 0, writable and readable
// R10 - Setting mode bits govern only while mode field is 00
// R11 - Per-regulator select picks setting; code clamped to ceiling
package buck_regs_pkg;
  localparam int ADDR_W = 9;
  localparam int CODE_W = 7;
  localparam logic [8:0] OFS_A_CEIL = 9'h0d5;
  localparam logic [8:0] OFS_B_CEIL = 9'h0d6;
  localparam logic [8:0] OFS_A_FIRST = 9'h0d7;
  localparam logic [8:0] OFS_A_SECOND = 9'h0d8;
  localparam logic [8:0] OFS_B_FIRST = 9'h0d9;
  localparam logic [8:0] OFS_B_SECOND = 9'h0da;
  localparam int MODE_BIT = 7;
  localparam logic [6:0] CODE_RESET = 7'h00;
  localparam logic MODE_BIT_RESET = 1'h0;
  localparam int BASE_MV = 300;
  localparam int STEP_MV = 10;
  localparam logic [1:0] MODE_BY_SETTING = 2'h0;
  localparam logic [1:0] MODE_AUTO_1PH = 2'h1;
  localparam logic [1:0] MODE_FORCE_PWM = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  typedef struct packed {
    logic auto_mode;
    logic [6:0] code;
  } target_t;

  typedef struct packed {
    logic [6:0] code;
    logic auto_mode;
  } drive_t;
endpackage

// file: rtl/buck_voltage_setting_regs.sv
// Purpose: Ceiling and target voltage registers for bucks A and B
// Assumes: Host port is synchronous; OTP values are stable while otp_load_i pulses
// Notes: Reads are registered, data valid one cycle after rd_en_i
`timescale 1ns/1ps
module buck_voltage_setting_regs (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [8:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wdata_i,
  input wire logic test_mode_i,
  input wire logic otp_load_i,
  input wire logic [6:0] otp_a_ceiling_i,
  input wire logic [6:0] otp_b_ceiling_i,
  input wire logic a_select_second_i,
  input wire logic b_select_second_i,
  input wire logic [1:0] regulator_a_operating_mode_field_i,
  input wire logic [1:0] regulator_b_operating_mode_field_i,
  output logic [7:0] rdata_o,
  output logic [6:0] a_code_o,
  output logic a_auto_mode_o,
  output logic [6:0] b_code_o,
  output logic b_auto_mode_o
);
  logic [6:0] a_ceil_q;
  logic [6:0] b_ceil_q;
  buck_regs_pkg::target_t a_first_q;
  buck_regs_pkg::target_t a_second_q;
  buck_regs_pkg::target_t b_first_q;
  buck_regs_pkg::target_t b_second_q;
  logic [7:0] rdata_q;
  buck_regs_pkg::drive_t a_drv_q;
  buck_regs_pkg::drive_t b_drv_q;

  // Register decode
  wire hit_a_ceil = addr_i == buck_regs_pkg::OFS_A_CEIL;
  wire hit_b_ceil = addr_i == buck_regs_pkg::OFS_B_CEIL;
  wire hit_a_first = addr_i == buck_regs_pkg::OFS_A_FIRST;
  wire hit_a_second = addr_i == buck_regs_pkg::OFS_A_SECOND;
  wire hit_b_first = addr_i == buck_regs_pkg::OFS_B_FIRST;
  wire hit_b_second = addr_i == buck_regs_pkg::OFS_B_SECOND;
  wire hit_any = hit_a_ceil | hit_b_ceil | hit_a_first
    | hit_a_second | hit_b_first | hit_b_second;

  // Ceiling writes need test mode; an OTP load wins over them
  wire ceil_wr_ok = wr_en_i & test_mode_i; // see R3
  wire a_ceil_we = ceil_wr_ok & hit_a_ceil & !otp_load_i;
  wire b_ceil_we = ceil_wr_ok & hit_b_ceil & !otp_load_i;
  wire a_first_we = wr_en_i & hit_a_first; // see R9
  wire a_second_we = wr_en_i & hit_a_second;
  wire b_first_we = wr_en_i & hit_b_first;
  wire b_second_we = wr_en_i & hit_b_second;
  wire [6:0] wr_code = wdata_i[buck_regs_pkg::CODE_W-1:0];

  // Ceiling bit 7 is reserved and reads as zero
  wire [7:0] rd_mux =
    hit_a_ceil ? {1'b0, a_ceil_q} :
    hit_b_ceil ? {1'b0, b_ceil_q} :
    hit_a_first ? a_first_q :
    hit_a_second ? a_second_q :
    hit_b_first ? b_first_q :
    hit_b_second ? b_second_q : '0; // see R9

  // Selected setting per regulator
  wire buck_regs_pkg::target_t a_sel = a_select_second_i ? a_second_q : a_first_q; // see R11
  wire buck_regs_pkg::target_t b_sel = b_select_second_i ? b_second_q : b_first_q; // see R11

  // Codes are linear in voltage, so comparing codes compares voltages
  wire a_over = a_sel.code > a_ceil_q; // see R4
  wire b_over = b_sel.code > b_ceil_q; // see R4
  wire [6:0] a_clamp = a_over ? a_ceil_q : a_sel.code; // see R1
  wire [6:0] b_clamp = b_over ? b_ceil_q : b_sel.code; // see R2

  // Mode field 00 defers to the setting bit; 10 forces PWM; others automatic
  wire a_by_setting =
    regulator_a_operating_mode_field_i == buck_regs_pkg::MODE_BY_SETTING; // see R10
  wire a_forced_pwm =
    regulator_a_operating_mode_field_i == buck_regs_pkg::MODE_FORCE_PWM; // see R10
  wire a_auto = a_by_setting ? a_sel.auto_mode : !a_forced_pwm; // see R5 R6
  wire b_by_setting =
    regulator_b_operating_mode_field_i == buck_regs_pkg::MODE_BY_SETTING; // see R10
  wire b_forced_pwm =
    regulator_b_operating_mode_field_i == buck_regs_pkg::MODE_FORCE_PWM; // see R10
  wire b_auto = b_by_setting ? b_sel.auto_mode : !b_forced_pwm; // see R7 R8

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      a_ceil_q <= buck_regs_pkg::CODE_RESET;
      b_ceil_q <= buck_regs_pkg::CODE_RESET;
    end else if (otp_load_i) begin
      a_ceil_q <= otp_a_ceiling_i; // see R3
      b_ceil_q <= otp_b_ceiling_i;
    end else begin
      if (a_ceil_we) begin
        a_ceil_q <= wr_code;
      end
      if (b_ceil_we) begin
        b_ceil_q <= wr_code;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      a_first_q <= {buck_regs_pkg::MODE_BIT_RESET, buck_regs_pkg::CODE_RESET};
      a_second_q <= {buck_regs_pkg::MODE_BIT_RESET, buck_regs_pkg::CODE_RESET};
      b_first_q <= {buck_regs_pkg::MODE_BIT_RESET, buck_regs_pkg::CODE_RESET};
      b_second_q <= {buck_regs_pkg::MODE_BIT_RESET, buck_regs_pkg::CODE_RESET};
    end else begin
      if (a_first_we) begin
        a_first_q <= wdata_i; // see R9
      end
      if (a_second_we) begin
        a_second_q <= wdata_i;
      end
      if (b_first_we) begin
        b_first_q <= wdata_i;
      end
      if (b_second_we) begin
        b_second_q <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
      a_drv_q <= '0;
      b_drv_q <= '0;
    end else begin
      if (rd_en_i) begin
        rdata_q <= rd_mux;
      end
      a_drv_q <= {a_clamp, a_auto};
      b_drv_q <= {b_clamp, b_auto};
    end
  end

  assign rdata_o = rdata_q;
  assign a_code_o = a_drv_q.code;
  assign a_auto_mode_o = a_drv_q.auto_mode;
  assign b_code_o = b_drv_q.code;
  assign b_auto_mode_o = b_drv_q.auto_mode;

  a_ceil_a_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R1
    a_code_o <= a_ceil_q || $past(otp_load_i)
      || $past(ceil_wr_ok))
    else $error("buck A code above ceiling");

  a_ceil_b_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R2
    b_code_o <= b_ceil_q || $past(otp_load_i)
      || $past(ceil_wr_ok))
    else $error("buck B code above ceiling");

  a_ceil_write_lock: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R3
    wr_en_i && !test_mode_i && !otp_load_i
    |=> $stable(a_ceil_q) && $stable(b_ceil_q))
    else $error("ceiling changed outside test mode");

  a_ceil_idle_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R3
    !otp_load_i && !ceil_wr_ok
    |=> $stable(a_ceil_q) && $stable(b_ceil_q))
    else $error("ceiling changed without load or write");

  a_ceil_a_write: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R3
    a_ceil_we
    |=> a_ceil_q == $past(wr_code))
    else $error("buck A ceiling test write lost");

  a_ceil_b_write: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R3
    b_ceil_we
    |=> b_ceil_q == $past(wr_code))
    else $error("buck B ceiling test write lost");

  a_ceil_otp_load: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R3
    otp_load_i
    |=> a_ceil_q == $past(otp_a_ceiling_i) && b_ceil_q == $past(otp_b_ceiling_i))
    else $error("ceiling OTP load lost");

  a_a_first_mode: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R5
    !a_select_second_i
      && regulator_a_operating_mode_field_i == buck_regs_pkg::MODE_BY_SETTING
    |=> a_auto_mode_o == $past(a_first_q.auto_mode))
    else $error("buck A first setting mode wrong");

  a_a_second_mode: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R6
    a_select_second_i
      && regulator_a_operating_mode_field_i == buck_regs_pkg::MODE_BY_SETTING
    |=> a_auto_mode_o == $past(a_second_q.auto_mode))
    else $error("buck A second setting mode wrong");

  a_b_first_mode: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R7
    !b_select_second_i
      && regulator_b_operating_mode_field_i == buck_regs_pkg::MODE_BY_SETTING
    |=> b_auto_mode_o == $past(b_first_q.auto_mode))
    else $error("buck B first setting mode wrong");

  a_b_second_mode: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R8
    b_select_second_i
      && regulator_b_operating_mode_field_i == buck_regs_pkg::MODE_BY_SETTING
    |=> b_auto_mode_o == $past(b_second_q.auto_mode))
    else $error("buck B second setting mode wrong");

  a_mode_override: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R10
    regulator_a_operating_mode_field_i == buck_regs_pkg::MODE_FORCE_PWM
    |=> !a_auto_mode_o)
    else $error("buck A forced PWM field ignored");

  a_b_forced_pwm: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R10
    regulator_b_operating_mode_field_i == buck_regs_pkg::MODE_FORCE_PWM
    |=> !b_auto_mode_o)
    else $error("buck B forced PWM field ignored");

  a_a_auto_field: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R10
    regulator_a_operating_mode_field_i == buck_regs_pkg::MODE_AUTO_1PH
      || regulator_a_operating_mode_field_i == buck_regs_pkg::MODE_AUTO
    |=> a_auto_mode_o)
    else $error("buck A automatic field ignored");

  a_b_auto_field: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R10
    regulator_b_operating_mode_field_i == buck_regs_pkg::MODE_AUTO_1PH
      || regulator_b_operating_mode_field_i == buck_regs_pkg::MODE_AUTO
    |=> b_auto_mode_o)
    else $error("buck B automatic field ignored");

  a_a_first_code: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R11
    !a_select_second_i && a_first_q.code <= a_ceil_q
    |=> a_code_o == $past(a_first_q.code))
    else $error("buck A first code not applied");

  a_a_second_code: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R11
    a_select_second_i && a_second_q.code <= a_ceil_q
    |=> a_code_o == $past(a_second_q.code))
    else $error("buck A second code not applied");

  a_b_first_code: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R11
    !b_select_second_i && b_first_q.code <= b_ceil_q
    |=> b_code_o == $past(b_first_q.code))
    else $error("buck B first code not applied");

  a_b_second_code: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R11
    b_select_second_i && b_second_q.code <= b_ceil_q
    |=> b_code_o == $past(b_second_q.code))
    else $error("buck B second code not applied");

  a_a_clamp_top: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R1
    a_over
    |=> a_code_o == $past(a_ceil_q))
    else $error("buck A code not clamped");

  a_b_clamp_top: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R2
    b_over
    |=> b_code_o == $past(b_ceil_q))
    else $error("buck B code not clamped");

  a_target_readback: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R9
    wr_en_i && hit_a_first ##1 rd_en_i && hit_a_first && !wr_en_i
    |=> rdata_o == $past(wdata_i, 2))
    else $error("target readback mismatch");

  a_rd_a_ceil: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R1
    rd_en_i && hit_a_ceil
    |=> rdata_o == {1'b0, $past(a_ceil_q)})
    else $error("buck A ceiling read wrong");

  a_rd_b_ceil: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R2
    rd_en_i && hit_b_ceil
    |=> rdata_o == {1'b0, $past(b_ceil_q)})
    else $error("buck B ceiling read wrong");

  a_rd_a_first: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R9
    rd_en_i && hit_a_first
    |=> rdata_o == $past(a_first_q))
    else $error("buck A first target read wrong");

  a_rd_a_second: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R9
    rd_en_i && hit_a_second
    |=> rdata_o == $past(a_second_q))
    else $error("buck A second target read wrong");

  a_rd_b_first: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R9
    rd_en_i && hit_b_first
    |=> rdata_o == $past(b_first_q))
    else $error("buck B first target read wrong");

  a_rd_b_second: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R9
    rd_en_i && hit_b_second
    |=> rdata_o == $past(b_second_q))
    else $error("buck B second target read wrong");

  a_rd_unmapped: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R9
    rd_en_i && !hit_any
    |=> rdata_o == '0)
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R9
    !rd_en_i
    |=> $stable(rdata_o))
    else $error("read data changed without a read");

  a_target_lock: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R9
    !wr_en_i
    |=> $stable(a_first_q) && $stable(a_second_q)
      && $stable(b_first_q) && $stable(b_second_q))
    else $error("target changed without a write");

  a_reset_clear: assert property (@(posedge clk_i) // see R1 R2
    !rstn_i
    |=> rdata_o == '0 && a_code_o == '0 && b_code_o == '0)
    else $error("outputs not cleared by reset");
endmodule

// file: verif/buck_host_model.sv
// Purpose: Host processor model for the register port
// Assumes: Requests launched 1 ns after rising clk_i
// Notes: Released bus shows inverted last address and data
`timescale 1ns/1ps
module buck_host_model (
  input wire logic clk_i,
  output logic [8:0] addr_o,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] wdata_o
);
  initial begin
    addr_o = 9'h000;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wdata_o = 8'h00;
  end
  // One byte write or read, held for one taking edge
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_en_o = w;
    rd_en_o = !w;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // Write then read the same register on the next edge
  task automatic wr_rd(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    rd_en_o = 1'b0;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    rd_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_en_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

// file: verif/buck_voltage_setting_regs_tb_top.sv
// Purpose: Self-checking bench for the buck voltage setting registers
// Assumes: Drive outputs settle one edge after a select or mode change
// Notes: OTP ceilings fixed at 0x46 and 0x20
`timescale 1ns/1ps
module buck_voltage_setting_regs_tb_top;
  logic clk, rstn, wr_en, rd_en, test_mode, otp_load, sel_a, sel_b, a_auto, b_auto;
  logic [8:0] addr;
  logic [7:0] wdata, rdata;
  logic [6:0] a_code, b_code;
  logic [1:0] mode;
  int fails = 0;
  int samples_checked = 0;
  buck_voltage_setting_regs dut_u (.clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .wdata_i(wdata), .test_mode_i(test_mode), .otp_load_i(otp_load),
    .otp_a_ceiling_i(7'h46), .otp_b_ceiling_i(7'h20), .a_select_second_i(sel_a),
    .b_select_second_i(sel_b), .regulator_a_operating_mode_field_i(mode),
    .regulator_b_operating_mode_field_i(mode), .rdata_o(rdata), .a_code_o(a_code),
    .a_auto_mode_o(a_auto), .b_code_o(b_code), .b_auto_mode_o(b_auto));
  buck_host_model host_u (.clk_i(clk), .addr_o(addr), .wr_en_o(wr_en), .rd_en_o(rd_en),
    .wdata_o(wdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
    host_u.acc(1'b0, a, 8'h00);
    check(rdata, exp);
  endtask
  task automatic pick(input logic s_a, input logic s_b, input logic [1:0] m);
    sel_a = s_a;
    sel_b = s_b;
    mode = m;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    {rstn, test_mode, otp_load, sel_a, sel_b, mode} = 7'h00;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 7; i++) rd_chk(9'h0d5 + 9'(i), 8'h00);
    host_u.acc(1'b1, 9'h0d5, 8'h7f);
    rd_chk(9'h0d5, 8'h00);
    otp_load = 1'b1;
    @(posedge clk);
    #1;
    otp_load = 1'b0;
    rd_chk(9'h0d5, 8'h46);
    rd_chk(9'h0d6, 8'h20);
    test_mode = 1'b1;
    host_u.acc(1'b1, 9'h0d6, 8'hff);
    test_mode = 1'b0;
    rd_chk(9'h0d6, 8'h7f);
    host_u.acc(1'b1, 9'h0d7, 8'h85);
    host_u.acc(1'b1, 9'h0d8, 8'h7f);
    host_u.acc(1'b1, 9'h0d9, 8'h90);
    host_u.acc(1'b1, 9'h0da, 8'h7f);
    rd_chk(9'h0d7, 8'h85);
    rd_chk(9'h0d9, 8'h90);
    pick(1'b0, 1'b0, 2'h0);
    check({a_auto, a_code}, 8'h85);
    check({b_auto, b_code}, 8'h90);
    pick(1'b1, 1'b1, 2'h0);
    check({a_auto, a_code}, 8'h46);
    check({b_auto, b_code}, 8'h7f);
    for (int m = 1; m < 4; m++) begin
      pick(1'b1, 1'b1, 2'(m));
      check({6'h00, b_auto, a_auto}, {6'h00, m != 2, m != 2});
    end
    host_u.wr_rd(9'h0d7, 8'h3c);
    check(rdata, 8'h3c);
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    rd_chk(9'h0d7, 8'h00);
    check({a_auto, a_code}, 8'h80);
    give_verdict();
  end
endmodule
